// *** pcs_pkg.sv ***
// Constants and types shared by the program counter and return stack block
package pcs_pkg;
	// ==========================================================
	// Sizes
	localparam int PC_W = 21;
	localparam int SP_W = 5;
	localparam int STACK_DEPTH = 31;
	localparam int ADDR_W = 8;

	// ==========================================================
	// Register byte offsets on the register bus
	localparam logic [ADDR_W-1:0] ADDR_PC_LOW_BYTE = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_PC_HIGH_LATCH = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_PC_UPPER_LATCH = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STACK_POINTER = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_TOP_LOW = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_TOP_HIGH = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_TOP_UPPER = 8'h18;
	localparam logic [ADDR_W-1:0] ADDR_RESET_CAUSE = 8'h1C;
	localparam logic [ADDR_W-1:0] ADDR_STACK_CONFIG = 8'h20;

	// ==========================================================
	// Field positions and values after reset
	localparam int OVF_BIT = 0;
	localparam int UNF_BIT = 1;
	localparam int FAULT_EN_BIT = 0;
	localparam logic FAULT_EN_RESET = 1'b1;
	localparam logic [SP_W-1:0] SP_EMPTY = 5'h00;
	localparam logic [SP_W-1:0] SP_FULL = 5'h1F;
	localparam logic [SP_W-1:0] SP_ONE = 5'h01;
	localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Operations issued by the instruction sequencer
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_SEQ = 3'b001,
		OP_JUMP = 3'b010,
		OP_CALL = 3'b011,
		OP_RET = 3'b100,
		OP_IRQ = 3'b101,
		OP_SW_PUSH = 3'b110,
		OP_SW_POP = 3'b111
	} pcs_op_e;
endpackage : pcs_pkg

// *** pcs_stack_if.sv ***
// Port bundle between the core and the return address storage
`timescale 1ns/100ps
interface pcs_stack_if import pcs_pkg::*; ();
	logic wr_en;
	logic [SP_W-1:0] wr_idx;
	logic [PC_W-1:0] wr_data;
	logic [SP_W-1:0] rd_idx;
	logic [PC_W-1:0] rd_data;

	modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
	modport ram (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : pcs_stack_if

// *** pcs_stack_ram.sv ***
// Return address storage: entries 1..DEPTH, index zero has no storage
`timescale 1ns/100ps
module pcs_stack_ram import pcs_pkg::*; #(
	parameter int DEPTH = STACK_DEPTH
) (
	// Clock
	input wire logic aclk,
	// Storage port
	pcs_stack_if.ram port
);
	logic [PC_W-1:0] mem [1:DEPTH];

	// ==========================================================
	// Write and read
	// No reset on the array: only the pointer is cleared, as in a real stack RAM
	always_ff @(posedge aclk) begin
		if (port.wr_en && (port.wr_idx != SP_EMPTY)) begin
			mem[port.wr_idx] <= port.wr_data;
		end
	end

	// Index zero is only the empty marker and reads as zero
	assign port.rd_data = (port.rd_idx == SP_EMPTY) ? PC_RESET : mem[port.rd_idx];
endmodule : pcs_stack_ram

// *** pcs_core.sv ***
// Program counter, pc latches and hardware return stack with AXI4-Lite registers
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
module pcs_core import pcs_pkg::*; #(
	parameter int DEPTH = STACK_DEPTH
) (
	// Clock and power-on reset
	input wire logic aclk,
	input wire logic aresetn,
	// Any other device reset, same clock
	input wire logic sys_reset,
	// Instruction sequencer
	input wire pcs_op_e seq_op,
	input wire logic [PC_W-1:0] seq_target,
	output logic [PC_W-1:0] pc,
	output logic fault_reset_req,
	// AXI4-Lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	// ==========================================================
	// State
	logic [SP_W-1:0] stack_pointer_register;
	logic [7:0] pc_high_latch;
	logic [4:0] pc_upper_latch;
	logic stack_overflow_flag;
	logic stack_underflow_flag;
	logic stack_fault_reset_enable;

	logic is_push;
	logic is_pop;
	logic push_full;
	logic pop_empty;
	logic fault;
	logic seq_idle;
	logic wr_go;
	logic wr_hit;
	logic rd_go;
	logic [7:0] wbyte;
	logic [PC_W-1:0] top_of_stack;
	logic [PC_W-1:0] next_top;

	pcs_stack_if stk ();

	pcs_stack_ram #(.DEPTH(DEPTH)) u_ram (
		.aclk(aclk),
		.port(stk.ram)
	);

	// ==========================================================
	// Decoding helpers
	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_PC_LOW_BYTE, ADDR_PC_HIGH_LATCH, ADDR_PC_UPPER_LATCH, ADDR_STACK_POINTER,
			ADDR_TOP_LOW, ADDR_TOP_HIGH, ADDR_TOP_UPPER, ADDR_RESET_CAUSE,
			ADDR_STACK_CONFIG: addr_mapped = 1'b1;
			default: addr_mapped = 1'b0;
		endcase
	endfunction : addr_mapped

	function automatic logic [31:0] read_value(
		input logic [ADDR_W-1:0] a,
		input logic [PC_W-1:0] p,
		input logic [PC_W-1:0] t,
		input logic [SP_W-1:0] s,
		input logic [7:0] lh,
		input logic [4:0] lu,
		input logic ov,
		input logic un,
		input logic en
	);
		read_value = 32'h00000000;
		case (a)
			ADDR_PC_LOW_BYTE: read_value[7:0] = p[7:0];
			ADDR_PC_HIGH_LATCH: read_value[7:0] = lh;
			ADDR_PC_UPPER_LATCH: read_value[4:0] = lu;
			ADDR_STACK_POINTER: read_value[SP_W-1:0] = s;
			ADDR_TOP_LOW: read_value[7:0] = t[7:0];
			ADDR_TOP_HIGH: read_value[7:0] = t[15:8];
			ADDR_TOP_UPPER: read_value[4:0] = t[20:16];
			ADDR_RESET_CAUSE: begin
				read_value[OVF_BIT] = ov;
				read_value[UNF_BIT] = un;
			end
			ADDR_STACK_CONFIG: read_value[FAULT_EN_BIT] = en;
			default: read_value = 32'h00000000;
		endcase
	endfunction : read_value

	// ==========================================================
	// Sequencer decode
	assign is_push = (seq_op == OP_CALL) || (seq_op == OP_IRQ) || (seq_op == OP_SW_PUSH);
	assign is_pop = (seq_op == OP_RET) || (seq_op == OP_SW_POP);
	assign push_full = is_push && (stack_pointer_register == SP_FULL);
	assign pop_empty = is_pop && (stack_pointer_register == SP_EMPTY);
	assign fault = (push_full || pop_empty) && stack_fault_reset_enable;
	assign seq_idle = (seq_op == OP_NONE);

	// ==========================================================
	// Bus handshakes
	// Bus accesses wait while the sequencer acts, so the two never race on state
	assign wr_go = awvalid && wvalid && !bvalid && seq_idle && !sys_reset;
	assign awready = wr_go;
	assign wready = wr_go;
	assign wr_hit = wr_go && wstrb[0] && addr_mapped(awaddr);
	assign rd_go = arvalid && !rvalid && seq_idle && !sys_reset;
	assign arready = rd_go;
	assign wbyte = wdata[7:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp <= addr_mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= 32'h00000000;
		end else if (rd_go) begin
			rvalid <= 1'b1;
			rresp <= addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			rdata <= read_value(araddr, pc, top_of_stack, stack_pointer_register, pc_high_latch,
				pc_upper_latch, stack_overflow_flag, stack_underflow_flag,
				stack_fault_reset_enable);
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Stack storage port
	assign top_of_stack = stk.rd_data;
	assign stk.rd_idx = stack_pointer_register;

	always_comb begin
		next_top = top_of_stack;
		case (awaddr)
			ADDR_TOP_LOW: next_top[7:0] = wbyte;
			ADDR_TOP_HIGH: next_top[15:8] = wbyte;
			ADDR_TOP_UPPER: next_top[20:16] = wbyte[4:0];
			default: next_top = top_of_stack;
		endcase
	end

	always_comb begin
		stk.wr_en = 1'b0;
		stk.wr_idx = stack_pointer_register;
		stk.wr_data = next_top;
		if (is_push) begin
			// A full stack keeps rewriting its last entry unless the fault resets
			stk.wr_en = !fault;
			stk.wr_idx = push_full ? SP_FULL : stack_pointer_register + SP_ONE;
			stk.wr_data = pc;
		end else if (wr_hit && ((awaddr == ADDR_TOP_LOW) || (awaddr == ADDR_TOP_HIGH) ||
				(awaddr == ADDR_TOP_UPPER))) begin
			stk.wr_en = 1'b1;
		end
	end

	// ==========================================================
	// Program counter
	always_ff @(posedge aclk) begin
		if (!aresetn || sys_reset || fault) begin
			pc <= PC_RESET;
		end else begin
			case (seq_op)
				OP_SEQ, OP_SW_PUSH, OP_SW_POP: pc <= pc + PC_STEP;
				OP_JUMP, OP_CALL, OP_IRQ: pc <= {seq_target[PC_W-1:1], 1'b0};
				OP_RET: pc <= pop_empty ? PC_RESET : {top_of_stack[PC_W-1:1], 1'b0};
				OP_NONE: begin
					if (wr_hit && (awaddr == ADDR_PC_LOW_BYTE)) begin
						pc <= {pc_upper_latch, pc_high_latch, wbyte[7:1], 1'b0};
					end
				end
				default: pc <= pc;
			endcase
		end
	end

	// ==========================================================
	// Stack pointer
	always_ff @(posedge aclk) begin
		if (!aresetn || sys_reset || fault) begin
			stack_pointer_register <= SP_EMPTY;
		end else if (is_push) begin
			if (!push_full) begin
				stack_pointer_register <= stack_pointer_register + SP_ONE;
			end
		end else if (is_pop) begin
			if (!pop_empty) begin
				stack_pointer_register <= stack_pointer_register - SP_ONE;
			end
		end else if (wr_hit && (awaddr == ADDR_STACK_POINTER)) begin
			stack_pointer_register <= wbyte[SP_W-1:0];
		end
	end

	// ==========================================================
	// Pc latches: only the bus touches them, never calls or returns
	always_ff @(posedge aclk) begin
		if (!aresetn || sys_reset) begin
			pc_high_latch <= LATCH_RESET;
			pc_upper_latch <= LATCH_RESET[4:0];
		end else if (rd_go && (araddr == ADDR_PC_LOW_BYTE)) begin
			pc_high_latch <= pc[15:8];
			pc_upper_latch <= pc[20:16];
		end else if (wr_hit && (awaddr == ADDR_PC_HIGH_LATCH)) begin
			pc_high_latch <= wbyte;
		end else if (wr_hit && (awaddr == ADDR_PC_UPPER_LATCH)) begin
			pc_upper_latch <= wbyte[4:0];
		end
	end

	// ==========================================================
	// Fault flags: cleared by power-on reset or a software write, not by sys_reset; hardware set wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stack_overflow_flag <= 1'b0;
			stack_underflow_flag <= 1'b0;
		end else begin
			if (push_full) begin
				stack_overflow_flag <= 1'b1;
			end else if (wr_hit && (awaddr == ADDR_RESET_CAUSE)) begin
				stack_overflow_flag <= wbyte[OVF_BIT];
			end
			if (pop_empty) begin
				stack_underflow_flag <= 1'b1;
			end else if (wr_hit && (awaddr == ADDR_RESET_CAUSE)) begin
				stack_underflow_flag <= wbyte[UNF_BIT];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stack_fault_reset_enable <= FAULT_EN_RESET;
		end else if (wr_hit && (awaddr == ADDR_STACK_CONFIG)) begin
			stack_fault_reset_enable <= wbyte[FAULT_EN_BIT];
		end
	end

	// Software writes to the flags never reach this request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_reset_req <= 1'b0;
		end else begin
			fault_reset_req <= fault && !sys_reset;
		end
	end

	// ==========================================================
	// Assertions
	a_pc_lsb_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		pc[0] == 1'b0)
		else $error("pc bit zero is not zero");

	a_seq_step_two: assert property (@(posedge aclk) disable iff (!aresetn)
		(seq_op == OP_SEQ) && !sys_reset |=> pc == PC_W'($past(pc) + PC_STEP))
		else $error("sequential step did not add two");

	a_call_push: assert property (@(posedge aclk) disable iff (!aresetn)
		(seq_op == OP_CALL) && (stack_pointer_register != SP_FULL) && !sys_reset |=>
		(stack_pointer_register == SP_W'($past(stack_pointer_register) + SP_ONE)) &&
		(top_of_stack == $past(pc)) && (pc == {$past(seq_target[PC_W-1:1]), 1'b0}))
		else $error("call did not push return address");

	a_ret_pop: assert property (@(posedge aclk) disable iff (!aresetn)
		(seq_op == OP_RET) && (stack_pointer_register != SP_EMPTY) && !sys_reset |=>
		(pc == {$past(top_of_stack[PC_W-1:1]), 1'b0}) &&
		(stack_pointer_register == SP_W'($past(stack_pointer_register) - SP_ONE)))
		else $error("return did not pop stack");

	a_ovf_fault: assert property (@(posedge aclk) disable iff (!aresetn)
		is_push && (stack_pointer_register == SP_FULL) && stack_fault_reset_enable &&
		!sys_reset |=> fault_reset_req && stack_overflow_flag &&
		(stack_pointer_register == SP_EMPTY) ##1 (!fault_reset_req || $past(pop_empty)))
		else $error("overflow with fault enable misbehaved");

	a_ovf_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		is_push && (stack_pointer_register == SP_FULL) && !stack_fault_reset_enable &&
		!sys_reset |=> stack_overflow_flag && !fault_reset_req &&
		(stack_pointer_register == SP_FULL) && (top_of_stack == $past(pc)))
		else $error("overflow without fault enable misbehaved");

	a_unf_zero_pc: assert property (@(posedge aclk) disable iff (!aresetn)
		(seq_op == OP_RET) && (stack_pointer_register == SP_EMPTY) && !sys_reset |=>
		(pc == PC_RESET) && stack_underflow_flag &&
		(fault_reset_req == $past(stack_fault_reset_enable)))
		else $error("underflow did not zero pc");

	a_pc_low_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_hit && (awaddr == ADDR_PC_LOW_BYTE) && !sys_reset |=>
		(pc[20:8] == {$past(pc_upper_latch), $past(pc_high_latch)}) &&
		(pc[7:1] == $past(wbyte[7:1])))
		else $error("pc low write did not load latches");

	a_pc_low_read: assert property (@(posedge aclk) disable iff (!aresetn)
		rd_go && (araddr == ADDR_PC_LOW_BYTE) |=>
		(pc_high_latch == $past(pc[15:8])) && (pc_upper_latch == $past(pc[20:16])))
		else $error("pc low read did not copy upper bytes");

	a_latch_stable: assert property (@(posedge aclk) disable iff (!aresetn)
		((seq_op == OP_CALL) || (seq_op == OP_RET)) && !sys_reset |=>
		$stable(pc_high_latch) && $stable(pc_upper_latch))
		else $error("call or return changed pc latches");

	a_sw_ovf_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_hit && (awaddr == ADDR_RESET_CAUSE) |=> !fault_reset_req)
		else $error("software flag write raised fault reset");

	a_resp_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before taken");
endmodule : pcs_core

// *** pcs_seq_model.sv ***
// Instruction sequencer model driving the operation port of the block
`timescale 1ns/100ps
module pcs_seq_model import pcs_pkg::*; (
	// Clock
	input wire logic aclk,
	// Software is inside a stack access
	input wire logic sw_busy,
	// Operation port
	output pcs_op_e seq_op,
	output logic [PC_W-1:0] seq_target
);
	initial begin
		seq_op = OP_NONE;
		seq_target = PC_RESET;
	end

	// ==========================================================
	// One operation per call, held for exactly one edge
	task automatic issue(input pcs_op_e op, input logic [PC_W-1:0] t);
		@(posedge aclk);
		// Interrupts stay masked while software touches the stack
		while (op == OP_IRQ && sw_busy) @(posedge aclk);
		seq_op <= op;
		seq_target <= t;
		@(posedge aclk);
		seq_op <= OP_NONE;
		// A stale target would hide a design that ignores the op code
		seq_target <= ~t;
	endtask : issue
endmodule : pcs_seq_model

// *** testbench.sv ***
// Self-checking bench for the program counter and return stack
`timescale 1ns/100ps
module testbench import pcs_pkg::*; ;
	logic aclk, aresetn, sys_reset;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, fault_reset_req;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [PC_W-1:0] pc, seq_target;
	logic sw_busy;
	pcs_op_e seq_op;
	int n_fail, checks, n_pulse, np;

	assign sw_busy = awvalid | arvalid;

	pcs_seq_model i_seq (.aclk(aclk), .sw_busy(sw_busy), .seq_op(seq_op),
		.seq_target(seq_target));
	pcs_core i_dut (.aclk(aclk), .aresetn(aresetn), .sys_reset(sys_reset),
		.seq_op(seq_op), .seq_target(seq_target), .pc(pc),
		.fault_reset_req(fault_reset_req), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp));

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		if (fault_reset_req === 1'b1)
			n_pulse++;
	end

	// ==========================================================
	// Shared helpers
	task automatic results;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(negedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		// Late bready makes the response wait a cycle, so its hold is exercised
		@(posedge aclk);
		bready <= 1'b1;
		do @(negedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
	endtask : rdc

	task automatic op(input pcs_op_e o, input logic [PC_W-1:0] t);
		i_seq.issue(o, t);
	endtask : op

	task automatic pcq(input logic [PC_W-1:0] e);
		@(negedge aclk);
		chk(32'(pc), 32'(e));
	endtask : pcq

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		rdc(ADDR_STACK_POINTER, 32'h00000000);
		rdc(ADDR_RESET_CAUSE, 32'h00000000);
		rdc(ADDR_STACK_CONFIG, 32'h00000001);
		rdc(ADDR_PC_HIGH_LATCH, 32'h00000000);
		pcq(21'h000000);
	endtask : t_reset

	task automatic t_seq;
		for (int i = 0; i < 3; i++) op(OP_SEQ, 21'h000000);
		pcq(21'h000006);
		wr(ADDR_PC_HIGH_LATCH, 32'h000000AB);
		wr(ADDR_PC_UPPER_LATCH, 32'h00000013);
		op(OP_JUMP, 21'h012345);
		pcq(21'h012344);
		wr(ADDR_PC_LOW_BYTE, 32'h00000057);
		chk(r, RESP_OKAY);
		pcq(21'h13AB56);
	endtask : t_seq

	task automatic t_read;
		op(OP_JUMP, 21'h1A5C38);
		rdc(ADDR_PC_LOW_BYTE, 32'h00000038);
		rdc(ADDR_PC_HIGH_LATCH, 32'h0000005C);
		rdc(ADDR_PC_UPPER_LATCH, 32'h0000001A);
	endtask : t_read

	task automatic t_call;
		wr(ADDR_PC_HIGH_LATCH, 32'h00000066);
		op(OP_CALL, 21'h000200);
		pcq(21'h000200);
		rdc(ADDR_STACK_POINTER, 32'h00000001);
		rdc(ADDR_TOP_LOW, 32'h00000038);
		rdc(ADDR_TOP_HIGH, 32'h0000005C);
		rdc(ADDR_TOP_UPPER, 32'h0000001A);
		op(OP_IRQ, 21'h000400);
		rdc(ADDR_STACK_POINTER, 32'h00000002);
		rdc(ADDR_TOP_HIGH, 32'h00000002);
		op(OP_RET, 21'h000000);
		pcq(21'h000200);
		op(OP_RET, 21'h000000);
		pcq(21'h1A5C38);
		rdc(ADDR_STACK_POINTER, 32'h00000000);
		rdc(ADDR_PC_HIGH_LATCH, 32'h00000066);
	endtask : t_call

	task automatic t_tos;
		op(OP_CALL, 21'h000300);
		wr(ADDR_TOP_LOW, 32'h00000020);
		op(OP_RET, 21'h000000);
		pcq(21'h1A5C20);
		wr(ADDR_STACK_POINTER, 32'h0000001F);
		rdc(ADDR_STACK_POINTER, 32'h0000001F);
		wr(ADDR_STACK_POINTER, 32'h00000000);
	endtask : t_tos

	task automatic t_swstack;
		op(OP_SW_PUSH, 21'h000000);
		pcq(21'h1A5C22);
		rdc(ADDR_TOP_LOW, 32'h00000020);
		rdc(ADDR_STACK_POINTER, 32'h00000001);
		op(OP_SW_POP, 21'h000000);
		rdc(ADDR_STACK_POINTER, 32'h00000000);
	endtask : t_swstack

	task automatic t_ovf;
		wr(ADDR_STACK_CONFIG, 32'h00000000);
		op(OP_JUMP, 21'h000010);
		np = n_pulse;
		for (int i = 0; i < 31; i++) op(OP_CALL, 21'h000010);
		rdc(ADDR_RESET_CAUSE, 32'h00000000);
		rdc(ADDR_STACK_POINTER, 32'h0000001F);
		op(OP_JUMP, 21'h000050);
		op(OP_CALL, 21'h000010);
		rdc(ADDR_RESET_CAUSE, 32'h00000001);
		rdc(ADDR_STACK_POINTER, 32'h0000001F);
		rdc(ADDR_TOP_LOW, 32'h00000050);
		wr(ADDR_RESET_CAUSE, 32'h00000000);
		rdc(ADDR_RESET_CAUSE, 32'h00000000);
		wr(ADDR_RESET_CAUSE, 32'h00000001);
		rdc(ADDR_RESET_CAUSE, 32'h00000001);
		chk(n_pulse, np);
		wr(ADDR_STACK_CONFIG, 32'h00000001);
		op(OP_CALL, 21'h000080);
		pcq(21'h000000);
		rdc(ADDR_STACK_POINTER, 32'h00000000);
		rdc(ADDR_RESET_CAUSE, 32'h00000001);
		chk(n_pulse, np + 1);
		wr(ADDR_RESET_CAUSE, 32'h00000000);
	endtask : t_ovf

	task automatic t_unf;
		wr(ADDR_STACK_CONFIG, 32'h00000000);
		op(OP_JUMP, 21'h000444);
		np = n_pulse;
		op(OP_RET, 21'h000000);
		pcq(21'h000000);
		rdc(ADDR_RESET_CAUSE, 32'h00000002);
		chk(n_pulse, np);
		wr(ADDR_STACK_CONFIG, 32'h00000001);
		wr(ADDR_RESET_CAUSE, 32'h00000000);
		op(OP_JUMP, 21'h000444);
		op(OP_RET, 21'h000000);
		pcq(21'h000000);
		rdc(ADDR_RESET_CAUSE, 32'h00000002);
		chk(n_pulse, np + 1);
	endtask : t_unf

	task automatic t_sysrst;
		op(OP_CALL, 21'h000600);
		@(posedge aclk);
		sys_reset <= 1'b1;
		@(posedge aclk);
		sys_reset <= 1'b0;
		rdc(ADDR_STACK_POINTER, 32'h00000000);
		rdc(ADDR_RESET_CAUSE, 32'h00000002);
	endtask : t_sysrst

	task automatic t_map;
		wr(8'h40, 32'h00000001);
		chk(r, RESP_SLVERR);
		rdc(8'h40, 32'h00000000);
		chk(r, RESP_SLVERR);
	endtask : t_map

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		aresetn = 1'b0;
		sys_reset = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h00000000;
		wstrb = 4'hF;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_seq();
		t_read();
		t_call();
		t_tos();
		t_swstack();
		t_ovf();
		t_unf();
		t_sysrst();
		t_map();
		results();
	end

	// Whole run needs well under a thousand cycles; ten thousand means a hang
	initial begin
		#400000;
		n_fail++;
		results();
	end
endmodule : testbench
